/* File: etx_ctrl.sv */
// Transmit data path control: command parsing, data FIFO feed, underrun, errors, stop
`include "etx_map.svh"
`default_nettype none
module etx_ctrl
    import etx_pkg::*;
(
    input wire logic CLK,                         // 10 MHz system clock
    input wire logic RESET,                       // Synchronous, active high
    input wire logic HOST_WR_VALID,               // Host writes one dword
    input wire logic [31:0] HOST_WR_DATA,         // Command or data dword
    input wire logic TX_CSUM_EN,                  // Global checksum enable
    input wire logic STORE_AND_FORWARD,           // No underrun detection
    input wire logic STATUS_DISCARD_OVR,          // Status discard on overrun
    input wire logic TX_DATA_DUMP,                // Flush data FIFO pulse
    input wire logic TX_ON_SET,                   // Set transmitter on
    input wire logic TX_STOP_SET,                 // Request stop
    input wire logic UNDERRUN_CLR,                // Clear underrun flag
    input wire logic TXE_CLR,                     // Clear error flag
    input wire logic MAC_READY,                   // MAC takes data
    input wire logic STATUS_FULL,                 // Status FIFO full
    output logic MAC_VALID,                       // Data dword valid
    output logic [31:0] MAC_DATA,                 // Data to MAC
    output logic MAC_EOF,                         // Last dword of frame
    output logic MAC_CSUM,                        // Frame is checksummed
    output logic STATUS_WR,                       // Status word push
    output logic [31:0] STATUS_WORD,              // Tag, error, underrun
    output logic [`ETX_FIFO_AW:0] TX_FIFO_USED,   // Data FIFO entries
    output logic UNDERRUN_FLAG,                   // Sticky underrun
    output logic TXE_FLAG,                        // Sticky transmitter error
    output logic TX_ON,                           // Transmitter on
    output logic TX_STOP,                         // Stop pending
    output logic TX_STOPPED                       // Stopped event pulse
);
    ////////////////////////////////////////////////////////////////////////
    // Data FIFO
    logic fifo_wr, fifo_rd, fifo_empty, fifo_full;
    logic [`ETX_ENTRY_W-1:0] fifo_wdata, fifo_head;
    logic [`ETX_FIFO_AW:0] fifo_count;
    etx_kind_t head_kind;

    etx_fifo u_fifo (
        .clk(CLK),
        .reset(RESET),
        .flush(TX_DATA_DUMP),
        .wr_en(fifo_wr),
        .wr_data(fifo_wdata),
        .rd_en(fifo_rd),
        .rd_data(fifo_head),
        .empty(fifo_empty),
        .full(fifo_full),
        .count(fifo_count)
    );
    assign head_kind = etx_kind_t'(fifo_head[`ETX_E_KIND_LSB +: 2]);
    assign TX_FIFO_USED = fifo_count;             // Counter flop inside the FIFO

    ////////////////////////////////////////////////////////////////////////
    // Host write parser
    etx_pstate_t p_reg, p_next;
    logic [31:0] a_reg, a_next, b_reg, b_next;
    logic [11:0] idx_reg, idx_next, skip_reg, skip_next, end_reg, end_next, tot_reg, tot_next;
    logic [11:0] acc_reg, acc_next;
    logic p_txe;

    // Decode command A into dword windows; partial offset and partial end dwords stay in
    always_comb
    begin
        logic [11:0] bytes;
        logic [11:0] mask;
        logic [11:0] acc_sum;
        logic [31:0] bref;
        bytes = 12'h000;
        mask = 12'h003;
        acc_sum = 12'h000;
        bref = b_reg;
        p_next = p_reg;
        a_next = a_reg;
        b_next = b_reg;
        idx_next = idx_reg;
        skip_next = skip_reg;
        end_next = end_reg;
        tot_next = tot_reg;
        acc_next = acc_reg;
        p_txe = 1'b0;
        fifo_wr = 1'b0;
        fifo_wdata = {1'b0, KIND_DATA, HOST_WR_DATA};
        if (HOST_WR_VALID)
        begin
            unique case (p_reg)
                P_CMDA:
                begin
                    bytes = {7'h00, HOST_WR_DATA[`ETX_A_OFF_LSB +: `ETX_A_OFF_W]}
                          + {1'b0, HOST_WR_DATA[`ETX_A_SIZE_LSB +: `ETX_A_SIZE_W]};
                    if (HOST_WR_DATA[`ETX_A_ALIGN_LSB +: `ETX_A_ALIGN_W] == `ETX_ALIGN_16)
                        mask = 12'h00f;
                    else if (HOST_WR_DATA[`ETX_A_ALIGN_LSB +: `ETX_A_ALIGN_W] == `ETX_ALIGN_32)
                        mask = 12'h01f;
                    a_next = HOST_WR_DATA;
                    skip_next = {9'h000, HOST_WR_DATA[`ETX_A_OFF_LSB + 2 +: 3]};
                    end_next = (bytes + 12'h003) >> 2;
                    tot_next = ((bytes + mask) & ~mask) >> 2;
                    fifo_wr = 1'b1;
                    fifo_wdata = {1'b0, KIND_CMDA, HOST_WR_DATA};
                    p_next = P_CMDB;
                end
                P_CMDB:
                begin
                    if (a_reg[`ETX_A_FS_BIT])
                    begin
                        fifo_wr = 1'b1;
                        fifo_wdata = {1'b0, KIND_CMDB, HOST_WR_DATA};
                        b_next = HOST_WR_DATA;
                        bref = HOST_WR_DATA;
                        acc_sum = {1'b0, a_reg[`ETX_A_SIZE_LSB +: `ETX_A_SIZE_W]};
                    end
                    else
                    begin
                        if (HOST_WR_DATA != b_reg)
                            p_txe = 1'b1;
                        acc_sum = acc_reg + {1'b0, a_reg[`ETX_A_SIZE_LSB +: `ETX_A_SIZE_W]};
                    end
                    acc_next = acc_sum;
                    if (a_reg[`ETX_A_LS_BIT] && acc_sum != {1'b0, bref[`ETX_B_LEN_LSB +: `ETX_B_LEN_W]})
                        p_txe = 1'b1;
                    idx_next = 12'h000;
                    p_next = (tot_reg == 12'h000) ? P_CMDA : P_DATA;
                end
                P_DATA:
                begin
                    // Offset and pad dwords outside the window are dropped
                    if (idx_reg >= skip_reg && idx_reg < end_reg)
                    begin
                        fifo_wr = 1'b1;
                        fifo_wdata = {a_reg[`ETX_A_LS_BIT] && idx_reg == end_reg - 12'h001,
                                      KIND_DATA, HOST_WR_DATA};
                    end
                    idx_next = idx_reg + 12'h001;
                    if (idx_reg == tot_reg - 12'h001)
                        p_next = P_CMDA;
                end
            endcase
            if (fifo_full && fifo_wr)
                p_txe = 1'b1;                     // Overfill drops the word
        end
    end

    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            p_reg <= P_CMDA;
            a_reg <= `ETX_RST_WORD;
            b_reg <= `ETX_RST_WORD;
            idx_reg <= `ETX_RST_CNT;
            skip_reg <= `ETX_RST_CNT;
            end_reg <= `ETX_RST_CNT;
            tot_reg <= `ETX_RST_CNT;
            acc_reg <= `ETX_RST_CNT;
        end
        else
        begin
            p_reg <= p_next;
            a_reg <= a_next;
            b_reg <= b_next;
            idx_reg <= idx_next;
            skip_reg <= skip_next;
            end_reg <= end_next;
            tot_reg <= tot_next;
            acc_reg <= acc_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Reader towards the MAC; commands are stripped here
    etx_rstate_t r_reg, r_next;
    logic mac_valid_reg, mac_valid_next, mac_eof_reg, mac_eof_next, csum_reg, csum_next;
    logic [31:0] mac_data_reg, mac_data_next, st_word_reg, st_word_next;
    logic st_wr_reg, st_wr_next, fs_reg, fs_next, under_reg, under_next;
    logic [15:0] tag_reg, tag_next;
    logic mac_space, start_ok, r_txe, underrun_evt, stop_done;

    assign mac_space = !mac_valid_reg || MAC_READY;
    assign start_ok = TX_ON && !TX_STOP && (!STATUS_FULL || STATUS_DISCARD_OVR);
    assign stop_done = TX_STOP && r_reg == R_IDLE;

    // Next-state logic of the reader; a dump returns it to idle
    always_comb
    begin
        r_next = r_reg;
        mac_valid_next = mac_valid_reg && !MAC_READY;
        mac_data_next = mac_data_reg;
        mac_eof_next = mac_eof_reg;
        csum_next = csum_reg;
        st_word_next = st_word_reg;
        st_wr_next = 1'b0;
        fs_next = fs_reg;
        under_next = under_reg;
        tag_next = tag_reg;
        fifo_rd = 1'b0;
        r_txe = 1'b0;
        underrun_evt = 1'b0;
        unique case (r_reg)
            R_IDLE:
            begin
                if (start_ok && !fifo_empty)
                begin
                    fifo_rd = 1'b1;
                    // Only a command A opens a frame; stray words are skipped
                    if (head_kind == KIND_CMDA)
                    begin
                        fs_next = fifo_head[`ETX_A_FS_BIT];
                        csum_next = 1'b0;
                        under_next = 1'b0;
                        tag_next = 16'h0000;
                        r_next = R_SEND;
                    end
                end
            end
            R_SEND:
            begin
                if (mac_space && !fifo_empty)
                begin
                    fifo_rd = 1'b1;
                    unique case (head_kind)
                        KIND_CMDA:
                            fs_next = fifo_head[`ETX_A_FS_BIT];
                        KIND_CMDB:
                        begin
                            csum_next = fifo_head[`ETX_B_CK_BIT] && fs_reg && TX_CSUM_EN;
                            tag_next = fifo_head[`ETX_B_TAG_LSB +: 16];
                        end
                        default:
                        begin
                            mac_valid_next = 1'b1;
                            mac_data_next = fifo_head[31:0];
                            mac_eof_next = fifo_head[`ETX_E_LAST_BIT];
                            if (fifo_head[`ETX_E_LAST_BIT])
                                r_next = R_STAT;
                        end
                    endcase
                end
                else if (mac_space && fifo_empty && !STORE_AND_FORWARD)
                begin
                    underrun_evt = 1'b1;          // Rest of the frame is abandoned
                    under_next = 1'b1;
                    r_next = R_STAT;
                end
            end
            R_STAT:
            begin
                st_word_next = {tag_reg, 16'h0000};
                st_word_next[`ETX_ST_ES_BIT] = under_reg;
                st_word_next[`ETX_ST_UNDER_BIT] = under_reg;
                if (STATUS_FULL && STATUS_DISCARD_OVR)
                    st_wr_next = 1'b0;
                else
                begin
                    st_wr_next = 1'b1;
                    r_txe = STATUS_FULL;          // Overrun of the status FIFO
                end
                r_next = under_reg ? R_UNDER : R_IDLE;
            end
            R_UNDER:
                r_next = R_UNDER;                 // Leftover stays until dumped
        endcase
        if (TX_DATA_DUMP)
            r_next = R_IDLE;                      // Flush also with transmitter on
    end

    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            r_reg <= R_IDLE;
            mac_valid_reg <= 1'b0;
            mac_data_reg <= `ETX_RST_WORD;
            mac_eof_reg <= 1'b0;
            csum_reg <= 1'b0;
            st_word_reg <= `ETX_RST_WORD;
            st_wr_reg <= 1'b0;
            fs_reg <= 1'b0;
            under_reg <= 1'b0;
            tag_reg <= 16'h0000;
        end
        else
        begin
            r_reg <= r_next;
            mac_valid_reg <= mac_valid_next;
            mac_data_reg <= mac_data_next;
            mac_eof_reg <= mac_eof_next;
            csum_reg <= csum_next;
            st_word_reg <= st_word_next;
            st_wr_reg <= st_wr_next;
            fs_reg <= fs_next;
            under_reg <= under_next;
            tag_reg <= tag_next;
        end
    end

    assign MAC_VALID = mac_valid_reg;
    assign MAC_DATA = mac_data_reg;
    assign MAC_EOF = mac_eof_reg;
    assign MAC_CSUM = csum_reg;
    assign STATUS_WR = st_wr_reg;
    assign STATUS_WORD = st_word_reg;

    ////////////////////////////////////////////////////////////////////////
    // Sticky flags and transmitter on/stop; a set wins over a clear
    logic und_reg, und_next, txe_reg, txe_next, on_reg, on_next, stp_reg, stp_next, evt_reg, evt_next;
    always_comb
    begin
        und_next = (und_reg && !UNDERRUN_CLR) || underrun_evt;
        // Error only flags; nothing in the reader looks at it
        txe_next = (txe_reg && !TXE_CLR) || p_txe || r_txe;
        on_next = TX_ON_SET || (on_reg && !stop_done);
        stp_next = TX_STOP_SET || (stp_reg && !stop_done);
        evt_next = stop_done;
    end

    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            und_reg <= 1'b0;
            txe_reg <= 1'b0;
            on_reg <= 1'b0;
            stp_reg <= 1'b0;
            evt_reg <= 1'b0;
        end
        else
        begin
            und_reg <= und_next;
            txe_reg <= txe_next;
            on_reg <= on_next;
            stp_reg <= stp_next;
            evt_reg <= evt_next;
        end
    end

    assign UNDERRUN_FLAG = und_reg;
    assign TXE_FLAG = txe_reg;
    assign TX_ON = on_reg;
    assign TX_STOP = stp_reg;
    assign TX_STOPPED = evt_reg;

    ////////////////////////////////////////////////////////////////////////
    // Checks beside the logic
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);

    a_cmda_stored: assert property (HOST_WR_VALID && p_reg == P_CMDA |-> fifo_wr &&
        fifo_wdata[`ETX_E_KIND_LSB +: 2] == KIND_CMDA) else $error("command A not stored");
    a_cmdb_gated: assert property (fifo_wr && fifo_wdata[`ETX_E_KIND_LSB +: 2] == KIND_CMDB
        |-> a_reg[`ETX_A_FS_BIT]) else $error("command B stored without first segment");
    a_offset_drop: assert property (p_reg == P_DATA && idx_reg < skip_reg |-> !fifo_wr)
        else $error("offset dword stored");
    a_pad_drop: assert property (p_reg == P_DATA && idx_reg >= end_reg |-> !fifo_wr)
        else $error("pad dword stored");
    a_csum_gate: assert property ($rose(MAC_CSUM) |-> $past(TX_CSUM_EN) && fs_reg)
        else $error("checksum without enable");
    a_under_report: assert property (underrun_evt && !TX_DATA_DUMP ##1
        !(STATUS_FULL && STATUS_DISCARD_OVR) && !UNDERRUN_CLR |=>
        STATUS_WR && STATUS_WORD[`ETX_ST_UNDER_BIT] && UNDERRUN_FLAG) else $error("underrun not reported");
    a_under_stall: assert property (r_reg == R_UNDER |-> !fifo_rd ##1 (r_reg == R_UNDER || $past(TX_DATA_DUMP)))
        else $error("leftover data read");
    a_overfill_txe: assert property (HOST_WR_VALID && fifo_wr && fifo_full && !TXE_CLR |=> TXE_FLAG)
        else $error("overfill without error");
    a_stop_clear: assert property (stop_done && !TX_ON_SET && !TX_STOP_SET |=>
        !TX_ON && !TX_STOP && TX_STOPPED ##1 !TX_STOPPED) else $error("stop handshake wrong");
    a_status_pause: assert property (r_reg == R_IDLE && STATUS_FULL && !STATUS_DISCARD_OVR |-> !fifo_rd)
        else $error("frame started with status FIFO full");
    a_used_count: assert property (!$past(TX_DATA_DUMP) |-> TX_FIFO_USED ==
        $past(fifo_count) + ($past(fifo_wr && !fifo_full) ? 1 : 0) - ($past(fifo_rd && !fifo_empty) ? 1 : 0))
        else $error("used count drifted");

    c_frame_eof: cover property (MAC_VALID && MAC_READY && MAC_EOF);
    c_underrun: cover property (underrun_evt ##[1:20] TX_DATA_DUMP);
    c_stop: cover property (TX_STOPPED);
    c_csum: cover property (MAC_CSUM && MAC_VALID);
endmodule : etx_ctrl
`default_nettype wire

/* File: etx_map.svh */
// Constants of the transmit data path control: command fields, status bits, sizes
`ifndef ETX_MAP_SVH
`define ETX_MAP_SVH
// Command A fields
`define ETX_A_SIZE_LSB 0
`define ETX_A_SIZE_W 11
`define ETX_A_LS_BIT 12
`define ETX_A_FS_BIT 13
`define ETX_A_OFF_LSB 16
`define ETX_A_OFF_W 5
`define ETX_A_ALIGN_LSB 24
`define ETX_A_ALIGN_W 2
// End alignment codes
`define ETX_ALIGN_16 2'h1
`define ETX_ALIGN_32 2'h2
// Command B fields
`define ETX_B_LEN_LSB 0
`define ETX_B_LEN_W 11
`define ETX_B_CK_BIT 14
`define ETX_B_TAG_LSB 16
// Status word bits
`define ETX_ST_ES_BIT 15
`define ETX_ST_UNDER_BIT 1
// Data FIFO geometry and entry layout
`define ETX_FIFO_DEPTH 64
`define ETX_FIFO_AW 6
`define ETX_ENTRY_W 35
`define ETX_E_LAST_BIT 34
`define ETX_E_KIND_LSB 32
// Reset values
`define ETX_RST_WORD 32'h0000_0000
`define ETX_RST_CNT 12'h000
`endif

/* File: etx_pkg.sv */
// Types shared by the transmit data path control
`default_nettype none
package etx_pkg;
    typedef enum logic [1:0] {KIND_CMDA, KIND_CMDB, KIND_DATA} etx_kind_t;
    typedef enum {P_CMDA, P_CMDB, P_DATA} etx_pstate_t;
    typedef enum {R_IDLE, R_SEND, R_STAT, R_UNDER} etx_rstate_t;
endpackage : etx_pkg
`default_nettype wire

/* File: etx_fifo.sv */
// Data FIFO of the transmit path: flip-flop storage with flush and used count
`include "etx_map.svh"
`default_nettype none
module etx_fifo
    import etx_pkg::*;
(
    input wire logic clk,                                  // System clock
    input wire logic reset,                                // Synchronous reset
    input wire logic flush,                                // Discard all contents
    input wire logic wr_en,                                // Push one entry
    input wire logic [`ETX_ENTRY_W-1:0] wr_data,           // Entry to push
    input wire logic rd_en,                                // Pop head entry
    output logic [`ETX_ENTRY_W-1:0] rd_data,               // Head entry
    output logic empty,                                    // No entries
    output logic full,                                     // No room
    output logic [`ETX_FIFO_AW:0] count                    // Entries held
);
    logic [`ETX_ENTRY_W-1:0] mem_reg [`ETX_FIFO_DEPTH];
    logic [`ETX_FIFO_AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
    logic [`ETX_FIFO_AW:0] cnt_reg, cnt_next;
    logic do_wr, do_rd;

    ////////////////////////////////////////////////////////////////////////
    // Pointer and count update; flush wins over any push or pop
    assign do_wr = wr_en && !full;
    assign do_rd = rd_en && !empty;
    always_comb
    begin
        wp_next = wp_reg;
        rp_next = rp_reg;
        cnt_next = cnt_reg;
        if (flush)
        begin
            wp_next = '0;
            rp_next = '0;
            cnt_next = '0;
        end
        else
        begin
            if (do_wr)
                wp_next = wp_reg + 1'b1;
            if (do_rd)
                rp_next = rp_reg + 1'b1;
            // Every stored word counts, commands included
            cnt_next = cnt_reg + {{`ETX_FIFO_AW{1'b0}}, do_wr} - {{`ETX_FIFO_AW{1'b0}}, do_rd};
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            wp_reg <= '0;
            rp_reg <= '0;
            cnt_reg <= '0;
        end
        else
        begin
            wp_reg <= wp_next;
            rp_reg <= rp_next;
            cnt_reg <= cnt_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Storage entries; contents need no reset, the count guards them
    for (genvar i = 0; i < `ETX_FIFO_DEPTH; i++)
    begin : g_entry
        always_ff @(posedge clk)
        begin
            if (do_wr && !flush && wp_reg == i[`ETX_FIFO_AW-1:0])
                mem_reg[i] <= wr_data;
        end
    end

    assign rd_data = mem_reg[rp_reg];
    assign empty = (cnt_reg == '0);
    assign full = cnt_reg[`ETX_FIFO_AW];
    assign count = cnt_reg;
endmodule : etx_fifo
`default_nettype wire

/* File: etx_mac.sv */
// MAC side model: random stalls, counts beats and frame ends
`default_nettype none
module etx_mac (
    input wire logic clk, // System clock
    input wire logic valid, // Beat offered
    input wire logic eof, // Last beat
    output logic ready, // Beat taken
    output int beats, // Beats taken
    output int frames // Frames ended
);
    timeunit 1ns;
    timeprecision 1ns;
    int seed = 32'h00c0_ffee;
    initial {ready, beats, frames} = '0;
    // Stall at random so that held beats get exercised
    always @(posedge clk)
    begin
        ready <= $random(seed) % 3 != 0;
        if (valid && ready)
        begin
            beats <= beats + 1;
            frames <= frames + eof;
        end
    end
endmodule : etx_mac
`default_nettype wire

/* File: etx_ctrl_tb.sv */
// Self-checking bench of the transmit data path control
`include "etx_map.svh"
`default_nettype none
module etx_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rst = 1, wv = 0, cs = 0, ck = 0, sf = 0, so = 0, sfu = 0, dump = 0, on = 0, stp = 0;
    logic tc = 0, uc = 0, csq, mv, meof, mcs, swr, uf, transmitter_error_flag, ton, tst, tsd, rdy;
    logic [31:0] wd = 0, md, sw, lsw = 0;
    logic [15:0] tg;
    logic [`ETX_FIFO_AW:0] used;
    int n_mismatch = 0, checked = 0, seed = 32'h17fb15ae, cyc = 0, beats, frames, f, e, b, d, o, z;
    int aln[3] = '{4, 16, 32};
    etx_ctrl etx_ctrl_i (.CLK(clk), .RESET(rst), .HOST_WR_VALID(wv), .HOST_WR_DATA(wd), .TX_CSUM_EN(cs),
        .STORE_AND_FORWARD(sf), .STATUS_DISCARD_OVR(so), .TX_DATA_DUMP(dump), .TX_ON_SET(on), .TX_STOP_SET(stp),
        .UNDERRUN_CLR(uc), .TXE_CLR(tc), .MAC_READY(rdy), .STATUS_FULL(sfu), .MAC_VALID(mv), .MAC_DATA(md),
        .MAC_EOF(meof), .MAC_CSUM(mcs), .STATUS_WR(swr), .STATUS_WORD(sw), .TX_FIFO_USED(used),
        .UNDERRUN_FLAG(uf), .TXE_FLAG(transmitter_error_flag), .TX_ON(ton), .TX_STOP(tst), .TX_STOPPED(tsd));
    etx_mac etx_mac_i (.clk(clk), .valid(mv), .eof(meof), .ready(rdy), .beats(beats), .frames(frames));
    always #50 clk = ~clk;
    // Last status and checksum mark at frame end; a hang ends the run
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (swr === 1'b1) lsw <= sw;
        if (mv === 1'b1 && meof === 1'b1 && rdy) csq <= mcs;
        if (cyc == 40000)
        begin
            n_mismatch++;
            give_verdict();
        end
    end
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] want);
        checked++;
        if (seen !== want)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, want, seen);
        end
    endtask : chk
    // Back-to-back random dwords; strobe drops once at the end
    task automatic wraw(int k);
        repeat (k)
        begin
            wv <= 1'b1;
            wd <= $random(seed);
            @(posedge clk);
        end
        wv <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : wraw
    // One buffer, both commands and the first m data dwords only; e gets the entries it should store
    task automatic wbuf(int off, int sz, int al, bit fs, bit ls, int len, int m);
        int n;
        n = (off + sz + aln[al] - 1) / aln[al] * aln[al] / 4;
        e = 1 + fs + (off + sz + 3) / 4 - off / 4;
        if (fs) tg = cyc[15:0];
        wv <= 1'b1;
        wd <= {6'h0, al[1:0], 3'h0, off[4:0], 2'h0, fs, ls, 1'b0, sz[10:0]};
        @(posedge clk);
        wd <= {tg, 1'b0, ck, 3'h0, len[10:0]};
        @(posedge clk);
        wraw(n < m ? n : m);
    endtask : wbuf
    // One-cycle pulse: 0 dump, 1 on, 2 stop, 3 error clear, 4 underrun clear
    task automatic pulse(int k);
        {dump, on, stp, tc, uc} <= 5'h10 >> k;
        @(posedge clk);
        {dump, on, stp, tc, uc} <= 5'h0;
        repeat (2) @(posedge clk);
    endtask : pulse
    task automatic waitf(int fr);
        for (int i = 0; i < 900 && frames < fr; i++) @(posedge clk);
        repeat (6) @(posedge clk);
        chk("frames", frames, fr);
    endtask : waitf
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict
    // Main sequence
    initial
    begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        chk("reset", {used, uf, transmitter_error_flag, ton, tst}, 0);
        wbuf(0, 4, 0, 1, 0, 8, 99);
        wbuf(0, 4, 2, 0, 1, 8, 99);
        chk("used", used, 5);
        cs <= 1'b1;
        {d, b, f} = {32'd5, beats + 2, frames + 4};
        for (int t = 0; t < 3; t++)
        begin
            o = $unsigned($random(seed)) % 32;
            z = 1 + $unsigned($random(seed)) % 40;
            ck = $random(seed);
            wbuf(o, z, t, 1, 1, z, 99);
            {d, b} = {d + e, b + e - 2};
        end
        chk("used", used, d);
        pulse(1);
        waitf(f);
        chk("beats", beats, b);
        chk("stat", {used, lsw[31:15], lsw[1], transmitter_error_flag, csq}, {7'h0, tg, 3'h0, ck});
        $display("test commands done");
        wbuf(1, 8, 0, 1, 1, 9, 99);
        waitf(f + 1);
        chk("len", {transmitter_error_flag, ton}, 2'h3);
        $display("test length done");
        // Store-and-forward: the gap between buffers must not underrun
        sf <= 1'b1;
        pulse(3);
        wbuf(0, 4, 0, 1, 0, 8, 99);
        ck = ~ck;
        wbuf(0, 4, 0, 0, 1, 8, 99);
        waitf(f + 2);
        chk("cmdb", {transmitter_error_flag, uf}, 2'h2);
        sf <= 1'b0;
        pulse(3);
        f = frames;
        wbuf(0, 16, 0, 1, 1, 16, 1);
        for (int i = 0; i < 200 && uf !== 1'b1; i++) @(posedge clk);
        repeat (4) @(posedge clk);
        chk("under", {uf, lsw[1], transmitter_error_flag}, 3'h6);
        wraw(3);
        chk("left", used, 3);
        pulse(0);
        pulse(4);
        chk("dump", {used, ton, uf}, 9'h2);
        wbuf(3, 5, 1, 1, 1, 5, 99);
        waitf(f + 1);
        $display("test underrun done");
        // Stopped pulse lasts one cycle, so it is watched between edges
        stp <= 1'b1;
        @(posedge clk);
        stp <= 1'b0;
        for (int i = 0; i < 200 && tsd !== 1'b1; i++) @(negedge clk);
        chk("stop", {ton, tst, tsd}, 3'h1);
        @(posedge clk);
        wbuf(0, 8, 0, 1, 1, 8, 99);
        repeat (30) @(posedge clk);
        chk("held", frames, f + 1);
        pulse(1);
        waitf(f + 2);
        // Full status FIFO holds the next frame back
        sfu <= 1'b1;
        wbuf(0, 8, 0, 1, 1, 8, 99);
        repeat (20) @(posedge clk);
        chk("pause", frames, f + 2);
        sfu <= 1'b0;
        waitf(f + 3);
        pulse(2);
        wbuf(0, 300, 0, 1, 1, 300, 99);
        chk("over", transmitter_error_flag, 1);
        $display("test stop and overfill done");
        give_verdict();
    end
endmodule : etx_ctrl_tb
`default_nettype wire
